// >>> sbm_pkg.sv
package sbm_pkg;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SLEEP = 4'h1,
    OP_TRAP = 4'h2,
    OP_RTE = 4'h3,
    OP_LDC_IMM = 4'h4,
    OP_AND_FLAGS_IMMEDIATE = 4'h5,
    OP_ORC = 4'h6,
    OP_XOR_FLAGS_IMMEDIATE = 4'h7,
    OP_LDC_REG = 4'h8,
    OP_STC_REG = 4'h9,
    OP_LDC_POSTINC = 4'ha,
    OP_STC_PREDEC = 4'hb,
    OP_STC_DISP24 = 4'hc,
    OP_MOVE_B = 4'hd,
    OP_MOVE_W = 4'he
  } sbm_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_PUSH_PC = 4'h1,
    S_PUSH_CCR = 4'h2,
    S_VEC = 4'h3,
    S_POP_CCR = 4'h4,
    S_POP_PC = 4'h5,
    S_LOAD = 4'h6,
    S_STORE = 4'h7,
    S_MV_RD = 4'h8,
    S_MV_WR = 4'h9,
    S_WAIT = 4'ha
  } sbm_state_t;

  typedef struct packed {
    sbm_op_t op;
    logic [7:0] imm;
    logic [23:0] disp;
    logic [7:0] condition_code_register;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [15:0] count;
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
  } sbm_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [31:0] addr;
    logic [15:0] wdata;
  } sbm_mem_t;

  localparam logic [31:0] TRAP_VEC_BASE = 32'h0000_0010;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] LEN_SHORT = 32'h0000_0002;
  localparam logic [31:0] LEN_MOVE = 32'h0000_0004;
  localparam logic [31:0] LEN_INC_DEC = 32'h0000_0004;
  localparam logic [31:0] LEN_DISP24 = 32'h0000_000a;
  localparam int CYC_W = 20;
  localparam logic [CYC_W-1:0] ST_SHORT = 20'h00002;
  localparam logic [CYC_W-1:0] ST_TRAP = 20'h0000e;
  localparam logic [CYC_W-1:0] ST_RTE = 20'h0000a;
  localparam logic [CYC_W-1:0] ST_INC_DEC = 20'h00008;
  localparam logic [CYC_W-1:0] ST_DISP24 = 20'h0000c;
  localparam logic [CYC_W-1:0] ST_MOVE_BASE = 20'h00008;

endpackage

// >>> sbm_exec.sv
`timescale 1ns/1ps
module sbm_exec
  import sbm_pkg::*;
(
  // Clock, reset and enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Decoded instruction
  input wire logic start_in,
  input wire sbm_cmd_t cmd_in,
  input wire logic wake_in,
  // Memory bus
  output sbm_mem_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  // Results
  output logic busy_out,
  output logic done_out,
  output logic sleep_out,
  output logic [7:0] ccr_out,
  output logic [7:0] rd8_out,
  output logic [31:0] pc_out,
  output logic [31:0] sp_out,
  output logic [31:0] src_addr_out,
  output logic [31:0] dst_addr_out,
  output logic [15:0] count_out,
  output logic [15:0] src_ptr_out,
  output logic [15:0] dst_ptr_out
);

  sbm_state_t state;
  sbm_op_t op;
  logic [CYC_W-1:0] cyc;
  logic [CYC_W-1:0] min_cyc;
  logic [7:0] move_byte;
  logic [15:0] cnt_start;
  logic [15:0] cnt_next;
  logic [31:0] disp_addr;
  logic mem_done;
  logic [1:0] trap_num;

  assign mem_done = mem_out.valid && mem_ack_in;
  assign disp_addr = cmd_in.dst_addr + {{8{cmd_in.disp[23]}}, cmd_in.disp};
  assign cnt_start = (cmd_in.op == OP_MOVE_B) ? {8'h00, cmd_in.count[7:0]} : cmd_in.count;
  assign cnt_next = count_out - 16'h0001;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Memory waits only stretch a step; the final wait tops up to the
  // on-chip state count, so slow memory can only make it longer.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      op <= OP_NOP;
      cyc <= '0;
      min_cyc <= '0;
      move_byte <= 8'h00;
      mem_out <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      ccr_out <= 8'h80;
      rd8_out <= 8'h00;
      pc_out <= 32'h0000_0000;
      sp_out <= 32'h0000_0000;
      src_addr_out <= 32'h0000_0000;
      dst_addr_out <= 32'h0000_0000;
      count_out <= 16'h0000;
      src_ptr_out <= 16'h0000;
      dst_ptr_out <= 16'h0000;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (state != S_IDLE) begin
        cyc <= cyc + 20'h00001;
      end
      case (state)
        S_IDLE: begin
          if (start_in) begin
            op <= cmd_in.op;
            cyc <= 20'h00001;
            busy_out <= 1'b1;
            ccr_out <= cmd_in.condition_code_register;
            pc_out <= cmd_in.pc + LEN_SHORT;
            sp_out <= cmd_in.sp;
            src_addr_out <= cmd_in.src_addr;
            dst_addr_out <= cmd_in.dst_addr;
            count_out <= cmd_in.count;
            src_ptr_out <= cmd_in.src_ptr;
            dst_ptr_out <= cmd_in.dst_ptr;
            min_cyc <= ST_SHORT;
            state <= S_WAIT;
            case (cmd_in.op)
              OP_NOP: pc_out <= cmd_in.pc + LEN_SHORT;
              OP_SLEEP: pc_out <= cmd_in.pc + LEN_SHORT;
              OP_TRAP: begin
                min_cyc <= ST_TRAP;
                sp_out <= cmd_in.sp - STEP_WORD;
                mem_out <= {1'b1, 1'b1, 1'b1, cmd_in.sp - STEP_WORD, cmd_in.pc[15:0] + 16'h0002};
                state <= S_PUSH_PC;
              end
              OP_RTE: begin
                min_cyc <= ST_RTE;
                mem_out <= {1'b1, 1'b0, 1'b1, cmd_in.sp, 16'h0000};
                state <= S_POP_CCR;
              end
              OP_LDC_IMM, OP_LDC_REG: ccr_out <= cmd_in.imm;
              OP_AND_FLAGS_IMMEDIATE: ccr_out <= cmd_in.condition_code_register & cmd_in.imm;
              OP_ORC: ccr_out <= cmd_in.condition_code_register | cmd_in.imm;
              OP_XOR_FLAGS_IMMEDIATE: ccr_out <= cmd_in.condition_code_register ^ cmd_in.imm;
              OP_STC_REG: rd8_out <= cmd_in.condition_code_register;
              OP_LDC_POSTINC: begin
                min_cyc <= ST_INC_DEC;
                pc_out <= cmd_in.pc + LEN_INC_DEC;
                mem_out <= {1'b1, 1'b0, 1'b1, cmd_in.src_addr, 16'h0000};
                state <= S_LOAD;
              end
              OP_STC_PREDEC: begin
                min_cyc <= ST_INC_DEC;
                pc_out <= cmd_in.pc + LEN_INC_DEC;
                dst_addr_out <= cmd_in.dst_addr - STEP_WORD;
                mem_out <= {1'b1, 1'b1, 1'b1, cmd_in.dst_addr - STEP_WORD, cmd_in.condition_code_register, 8'h00};
                state <= S_STORE;
              end
              OP_STC_DISP24: begin
                min_cyc <= ST_DISP24;
                pc_out <= cmd_in.pc + LEN_DISP24;
                mem_out <= {1'b1, 1'b1, 1'b1, disp_addr, cmd_in.condition_code_register, 8'h00};
                state <= S_STORE;
              end
              OP_MOVE_B, OP_MOVE_W: begin
                min_cyc <= ST_MOVE_BASE + {2'b00, cnt_start, 2'b00};
                pc_out <= cmd_in.pc + LEN_MOVE;
                if (cnt_start != 16'h0000) begin
                  mem_out <= {1'b1, 1'b0, 1'b0, 16'h0000, cmd_in.src_ptr, 16'h0000};
                  state <= S_MV_RD;
                end
              end
              default: state <= S_WAIT;
            endcase
          end
        end
        S_PUSH_PC: begin
          if (mem_done) begin
            sp_out <= sp_out - STEP_WORD;
            mem_out <= {1'b1, 1'b1, 1'b1, sp_out - STEP_WORD, ccr_out, 8'h00};
            state <= S_PUSH_CCR;
          end
        end
        S_PUSH_CCR: begin
          if (mem_done) begin
            mem_out <= {1'b1, 1'b0, 1'b1, TRAP_VEC_BASE + {29'h0, trap_num, 1'b0}, 16'h0000};
            state <= S_VEC;
          end
        end
        S_VEC: begin
          if (mem_done) begin
            mem_out <= '0;
            pc_out <= {16'h0000, mem_rdata_in};
            state <= S_WAIT;
          end
        end
        S_POP_CCR: begin
          if (mem_done) begin
            ccr_out <= mem_rdata_in[15:8];
            sp_out <= sp_out + STEP_WORD;
            mem_out <= {1'b1, 1'b0, 1'b1, sp_out + STEP_WORD, 16'h0000};
            state <= S_POP_PC;
          end
        end
        S_POP_PC: begin
          if (mem_done) begin
            mem_out <= '0;
            pc_out <= {16'h0000, mem_rdata_in};
            sp_out <= sp_out + STEP_WORD;
            state <= S_WAIT;
          end
        end
        S_LOAD: begin
          if (mem_done) begin
            mem_out <= '0;
            ccr_out <= mem_rdata_in[15:8];
            src_addr_out <= src_addr_out + STEP_WORD;
            state <= S_WAIT;
          end
        end
        S_STORE: begin
          if (mem_done) begin
            mem_out <= '0;
            state <= S_WAIT;
          end
        end
        S_MV_RD: begin
          if (mem_done) begin
            move_byte <= mem_rdata_in[7:0];
            mem_out <= {1'b1, 1'b1, 1'b0, 16'h0000, dst_ptr_out, 8'h00, mem_rdata_in[7:0]};
            state <= S_MV_WR;
          end
        end
        S_MV_WR: begin
          if (mem_done) begin
            src_ptr_out <= src_ptr_out + 16'h0001;
            dst_ptr_out <= dst_ptr_out + 16'h0001;
            if (op == OP_MOVE_B) begin
              count_out <= {count_out[15:8], cnt_next[7:0]};
            end else begin
              count_out <= cnt_next;
            end
            if ((op == OP_MOVE_B) ? (cnt_next[7:0] != 8'h00) : (cnt_next != 16'h0000)) begin
              mem_out <= {1'b1, 1'b0, 1'b0, 16'h0000, src_ptr_out + 16'h0001, 16'h0000};
              state <= S_MV_RD;
            end else begin
              mem_out <= '0;
              state <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          // Finish no sooner than the on-chip count.
          if (cyc + 20'h00001 >= min_cyc) begin
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trap vector number and power-down
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      trap_num <= 2'h0;
    end else if (ce_in && state == S_IDLE && start_in) begin
      trap_num <= cmd_in.imm[1:0];
    end
  end

  // Wake has priority over a new sleep only outside its own finish cycle.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sleep_out <= 1'b0;
    end else if (ce_in) begin
      if (state == S_WAIT && op == OP_SLEEP && cyc + 20'h00001 >= min_cyc) begin
        sleep_out <= 1'b1;
      end else if (wake_in) begin
        sleep_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence go_s(sbm_op_t o);
    ce_in && start_in && state == S_IDLE && cmd_in.op == o;
  endsequence

  sequence wr_ack_s;
    ce_in && state == S_MV_WR && mem_done;
  endsequence

  trap_push_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    go_s(OP_TRAP) |=> mem_out.valid && mem_out.write && mem_out.addr == $past(cmd_in.sp) - 2)
    else $error("trap does not push below stack pointer");
  rte_pop_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    go_s(OP_RTE) |=> mem_out.valid && !mem_out.write && mem_out.addr == $past(cmd_in.sp))
    else $error("return does not read flags at stack pointer");
  sleep_time_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    done_out && op == OP_SLEEP |-> sleep_out && cyc == 20'h00002)
    else $error("sleep timing or state wrong");
  postinc_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && state == S_LOAD && mem_done |=>
      src_addr_out == $past(src_addr_out) + 2 && ccr_out == $past(mem_rdata_in[15:8]))
    else $error("post-increment load wrong");
  predec_store_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    go_s(OP_STC_PREDEC) |=> mem_out.addr == dst_addr_out && dst_addr_out == $past(cmd_in.dst_addr) - 2)
    else $error("pre-decrement store address wrong");
  disp_store_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    go_s(OP_STC_DISP24) |=> mem_out.word && mem_out.addr == $past(disp_addr)
      && pc_out == $past(cmd_in.pc) + 10)
    else $error("displacement store wrong");
  move_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    go_s(OP_MOVE_B) ##0 cnt_start == 16'h0000 |=> state == S_WAIT && !mem_out.valid)
    else $error("zero-count move touched memory");
  move_ptr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_ack_s |=> src_ptr_out == $past(src_ptr_out) + 1 && dst_ptr_out == $past(dst_ptr_out) + 1)
    else $error("move pointers not incremented");
  move_count_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_ack_s ##0 op == OP_MOVE_W |=> count_out == $past(count_out) - 1)
    else $error("word count not decremented");
  move_time_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    done_out && (op == OP_MOVE_B || op == OP_MOVE_W) |-> cyc >= min_cyc)
    else $error("block move finished too early");
  and_flags_immediate_flags_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    go_s(OP_AND_FLAGS_IMMEDIATE) |=> ccr_out == ($past(cmd_in.condition_code_register) & $past(cmd_in.imm)))
    else $error("flag AND wrong");

endmodule

// >>> sbm_mem_model.sv
`timescale 1ns/1ps
module sbm_mem_model
  import sbm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Bus from the executor
  input wire sbm_mem_t mem_in,
  input wire logic [3:0] waits_in,
  // Answer
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [7:0] ram [0:4095];
  logic [3:0] wcnt;
  logic [15:0] last;
  logic [11:0] a;
  assign a = mem_in.addr[11:0];
  // Each access is held off for waits_in cycles before it is answered.
  assign ack_out = mem_in.valid && (wcnt >= waits_in);
  // An idle bus shows the inverse of the last answer, so stale data cannot pass.
  assign rdata_out = !ack_out ? ~last :
    mem_in.word ? {ram[a], ram[a + 12'h001]} : {8'h00, ram[a]};
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !mem_in.valid || ack_out) begin
      wcnt <= 4'h0;
    end else begin
      wcnt <= wcnt + 4'h1;
    end
  end
  // Plain always, because the bench preloads the same array.
  always @(posedge sys_clk_in) begin
    if (ack_out) begin
      last <= rdata_out;
    end
    if (ack_out && mem_in.write && mem_in.word) begin
      ram[a] <= mem_in.wdata[15:8];
      ram[a + 12'h001] <= mem_in.wdata[7:0];
    end
    if (ack_out && mem_in.write && !mem_in.word) begin
      ram[a] <= mem_in.wdata[7:0];
    end
  end
endmodule

// >>> sbm_exec_tb.sv
`timescale 1ns/1ps
module sbm_exec_tb
  import sbm_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk_in = 1'b0;
  logic rst_in, ce, start, wake, ack, busy, done, sleep;
  logic [3:0] waits;
  logic [15:0] rdata, cnt, s_p, d_p;
  logic [7:0] condition_code_register, rd8;
  logic [31:0] pc, sp, sa, da;
  sbm_cmd_t cmd, c;
  sbm_mem_t bus;
  int mismatches = 0;
  int cmp_count = 0;
  int n;

  always #12.5 sys_clk_in = ~sys_clk_in;

  sbm_exec DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce), .start_in(start),
    .cmd_in(cmd), .wake_in(wake), .mem_out(bus), .mem_ack_in(ack), .mem_rdata_in(rdata),
    .busy_out(busy), .done_out(done), .sleep_out(sleep), .ccr_out(condition_code_register), .rd8_out(rd8),
    .pc_out(pc), .sp_out(sp), .src_addr_out(sa), .dst_addr_out(da), .count_out(cnt),
    .src_ptr_out(s_p), .dst_ptr_out(d_p));

  sbm_mem_model mem (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .mem_in(bus),
    .waits_in(waits), .ack_out(ack), .rdata_out(rdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic sbm_cmd_t mk(sbm_op_t op, logic [7:0] f, logic [7:0] im, logic [15:0] k);
    sbm_cmd_t r;
    r = '0;
    r.op = op;
    r.condition_code_register = f;
    r.imm = im;
    r.count = k;
    r.pc = 32'h0000_0100;
    r.sp = 32'h0000_0800;
    r.src_addr = 32'h0000_0200;
    r.dst_addr = 32'h0000_0300;
    r.src_ptr = 16'h0400;
    r.dst_ptr = 16'h0500;
    return r;
  endfunction

  // Starts one instruction, optionally freezes it, and counts cycles up to done.
  task automatic run(input sbm_cmd_t x, input int hold);
    @(posedge sys_clk_in);
    cmd <= x;
    start <= 1'b1;
    @(posedge sys_clk_in);
    start <= 1'b0;
    if (hold > 0) begin
      ce <= 1'b0;
      repeat (hold) @(posedge sys_clk_in);
      ce <= 1'b1;
    end
    // The cycle in which start stands counts as the first one.
    n = hold + 1;
    do begin
      @(posedge sys_clk_in);
      n++;
      @(negedge sys_clk_in);
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_short();
    sbm_op_t ops [5] = '{OP_LDC_IMM, OP_LDC_REG, OP_AND_FLAGS_IMMEDIATE, OP_ORC, OP_XOR_FLAGS_IMMEDIATE};
    logic [7:0] ex [5] = '{8'h5a, 8'h5a, 8'h42, 8'hdb, 8'h99};
    run(mk(OP_NOP, 8'h00, 8'h00, 16'h0000), 3);
    chk(n, 5);
    chk(pc, 32'h102);
    chk({busy, done}, 2'b01);
    for (int k = 0; k < 5; k++) begin
      run(mk(ops[k], 8'hc3, 8'h5a, 16'h0000), 0);
      chk(n, 2);
      chk(condition_code_register, ex[k]);
      chk(pc, 32'h102);
    end
    run(mk(OP_STC_REG, 8'ha5, 8'h00, 16'h0000), 0);
    chk({rd8, condition_code_register}, 16'ha5a5);
    run(mk(OP_SLEEP, 8'h3c, 8'h00, 16'h0000), 0);
    chk({n[7:0], condition_code_register, 7'h00, sleep}, 32'h023c01);
    @(posedge sys_clk_in);
    wake <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    wake <= 1'b0;
    @(negedge sys_clk_in);
    chk(sleep, 1'b0);
  endtask

  task automatic t_trap();
    mem.ram[12'h014] = 8'h12;
    mem.ram[12'h015] = 8'h34;
    run(mk(OP_TRAP, 8'h15, 8'h02, 16'h0000), 0);
    chk(n, 14);
    chk({mem.ram[12'h7fe], mem.ram[12'h7ff], mem.ram[12'h7fc]}, 24'h010215);
    chk(pc, 32'h1234);
    chk(sp, 32'h7fc);
    c = mk(OP_RTE, 8'h00, 8'h00, 16'h0000);
    c.sp = 32'h0000_07fc;
    // Five waits per access push both pops past the on-chip count.
    waits <= 4'h5;
    run(c, 0);
    waits <= 4'h0;
    chk(n, 14);
    chk(condition_code_register, 8'h15);
    chk(pc, 32'h102);
    chk(sp, 32'h800);
  endtask

  task automatic t_ldst();
    mem.ram[12'h200] = 8'h6b;
    mem.ram[12'h201] = 8'h00;
    run(mk(OP_LDC_POSTINC, 8'h00, 8'h00, 16'h0000), 0);
    chk({n[7:0], condition_code_register}, 16'h086b);
    chk(sa, 32'h202);
    run(mk(OP_STC_PREDEC, 8'h2e, 8'h00, 16'h0000), 0);
    chk({n[7:0], condition_code_register, mem.ram[12'h2fe]}, 24'h082e2e);
    chk(da, 32'h2fe);
    c = mk(OP_STC_DISP24, 8'h71, 8'h00, 16'h0000);
    c.disp = 24'hfffff0;
    run(c, 0);
    chk({n[7:0], mem.ram[12'h2f0]}, 16'h0c71);
    chk(pc, 32'h10a);
  endtask

  task automatic t_move();
    for (int i = 12'h500; i < 12'ha10; i++) mem.ram[i] = 8'hee;
    for (int i = 0; i < 258; i++) mem.ram[12'h400 + i] = i[7:0] ^ 8'h5a;
    c = mk(OP_MOVE_W, 8'h00, 8'h00, 16'h0102);
    c.dst_ptr = 16'h0900;
    run(c, 0);
    chk(n, 1040);
    chk({cnt, s_p, d_p}, 48'h0000_0502_0a02);
    chk({mem.ram[12'h901], mem.ram[12'ha01], mem.ram[12'ha02]}, 24'h5b5bee);
    run(mk(OP_MOVE_B, 8'h00, 8'h00, 16'h0700), 0);
    chk({n[7:0], cnt, s_p, d_p}, 56'h08_0700_0400_0500);
    run(mk(OP_MOVE_B, 8'h00, 8'h00, 16'h0703), 0);
    chk(n, 20);
    chk({cnt, s_p, d_p}, 48'h0700_0403_0503);
    chk({mem.ram[12'h500], mem.ram[12'h502], mem.ram[12'h503]}, 24'h5a58ee);
    // Two accesses of six cycles each outlast the twelve on-chip states.
    waits <= 4'h5;
    run(mk(OP_MOVE_B, 8'h00, 8'h00, 16'h0001), 0);
    waits <= 4'h0;
    chk(n, 14);
    chk(d_p, 16'h0501);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    wake = 1'b0;
    waits = 4'h0;
    cmd = '0;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(condition_code_register, 8'h80);
    t_short();
    t_trap();
    t_ldst();
    t_move();
    wrap_up();
  end
endmodule
